// ### axil_slave.sv
`timescale 1ns/100ps
`include "capture_timer_cfg.svh"
// axi4-lite slave front end: one write and one read at a time
module axil_slave (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address and data
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // register side
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_err,
   output logic rd_en,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);

   logic aw_held, next_aw_held; // address waiting
   logic w_held, next_w_held; // data waiting
   logic [7:0] next_wr_addr;
   logic [31:0] next_wr_data;
   logic [3:0] next_wr_strb;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;

   // handshakes and next values
   always_comb begin
      s_axi_awready = ~aw_held;
      s_axi_wready = ~w_held;
      s_axi_arready = ~s_axi_rvalid;
      wr_en = aw_held & w_held & ~s_axi_bvalid;
      rd_en = s_axi_arvalid & ~s_axi_rvalid;
      rd_addr = s_axi_araddr;
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      next_wr_strb = wr_strb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      // take address and data in either order
      if (s_axi_awvalid && !aw_held) begin
         next_aw_held = 1'b1;
         next_wr_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
         next_w_held = 1'b1;
         next_wr_data = s_axi_wdata;
         next_wr_strb = s_axi_wstrb;
      end
      // response once both are in
      if (wr_en) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      // read answers at the accepting edge
      if (rd_en) begin
         next_rvalid = 1'b1;
         next_rdata = rd_data;
         next_rresp = rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   // bus state registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= `WORD_RST;
         wr_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `RESP_OKAY;
         s_axi_rdata <= `WORD_RST;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
         wr_strb <= next_wr_strb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
      end
   end

endmodule

// ### capture_edge_filter.sv
`timescale 1ns/100ps
// accepts a level only after SAMPLES equal samples, reports edges
module capture_edge_filter #(
   parameter int SAMPLES = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // raw input
   input wire logic din,
   // filtered level and edge pulses
   output logic level,
   output logic rise,
   output logic fall
);

   logic [SAMPLES-2:0] hist; // past samples
   logic [SAMPLES-2:0] next_hist;
   logic next_level;
   logic agree; // all samples equal

   // agreement and next values
   always_comb begin
      agree = (hist == {(SAMPLES-1){din}});
      next_hist = (SAMPLES-1)'({hist, din});
      next_level = agree ? din : level;
      rise = agree & din & ~level;
      fall = agree & ~din & level;
   end

   // sample registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         hist <= '0;
         level <= 1'b0;
      end else begin
         hist <= next_hist;
         level <= next_level;
      end
   end

endmodule

// ### capture_pulse_source.sv
`timescale 1ns/100ps
// outside pulse source feeding the capture pins; all idle low
module capture_pulse_source (
   // timer clock
   input wire logic clk,
   // pins toward the timer
   output logic cap_pin,
   output logic tclk_pin,
   output logic flt_pin
);
   // quiet lines from time zero
   initial begin
      cap_pin = 1'b0;
      tclk_pin = 1'b0;
      flt_pin = 1'b0;
   end
   // one pulse of h clocks on the chosen pin, then a quiet gap
   task automatic pulse(input int sel, input int h);
      @(posedge clk);
      case (sel)
         0: cap_pin <= 1'b1;
         1: tclk_pin <= 1'b1;
         default: flt_pin <= 1'b1;
      endcase
      repeat (h) @(posedge clk);
      cap_pin <= 1'b0;
      tclk_pin <= 1'b0;
      flt_pin <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
endmodule

// ### capture_timer_cfg.svh
`ifndef CAPTURE_TIMER_CFG_SVH
`define CAPTURE_TIMER_CFG_SVH

// register byte offsets
`define REG_CTRL0 8'h00
`define REG_CTRL1 8'h04
`define REG_PERIOD 8'h08
`define REG_CAPT_A 8'h0c
`define REG_CAPT_B 8'h10
`define REG_COUNT 8'h14
`define REG_STATUS 8'h18

// control 0 fields
`define CTRL0_ON_BIT 0
// control 1 fields
`define CTRL1_MODE_LSB 0
`define CTRL1_OC_LSB 2
`define CTRL1_CLR_LSB 4
`define CTRL1_SRC_BIT 6
`define CTRL1_CCLR_BIT 7
`define CTRL1_OINIT_BIT 8
`define CTRL1_POL_BIT 9
`define CTRL1_NF_BIT 10
`define CTRL1_W 11
// status fields
`define STAT_AF_BIT 0
`define STAT_PF_BIT 1
`define STAT_LVL_BIT 2

// reset values
`define CTRL1_RST 11'h000
`define WORD_RST 32'h0000_0000

// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// timing: timer clock period, flag delay in half periods, least pulse
`define TCLK_PERIOD_NS 25
`define FLAG_DELAY_HALF 1
`define FLAG_DELAY_CYC ((`FLAG_DELAY_HALF + 1) / 2)
`define MIN_PULSE_TCLK 2

`endif

// ### capture_timer_pkg.sv
package capture_timer_pkg;

   // operating mode field
   typedef enum logic [1:0] {
      MODE_COMPARE = 2'b00,
      MODE_CAPTURE = 2'b01,
      MODE_PWM = 2'b10,
      MODE_TIMER = 2'b11
   } mode_t;

   // active capture edge field
   typedef enum logic [1:0] {
      EDGE_RISE = 2'b00,
      EDGE_FALL = 2'b01,
      EDGE_BOTH = 2'b10,
      EDGE_NONE = 2'b11
   } edge_sel_t;

   // merge write data into a word by byte strobes
   function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                              input logic [31:0] wdata,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = wdata[i*8 +: 8];
         end
      end
      return res;
   endfunction

endpackage

// ### periodic_timer_capture.sv
`timescale 1ns/100ps
`include "capture_timer_cfg.svh"
module periodic_timer_capture #(
   parameter int CNT_W = 16, // 10 or 16
   parameter bit DUAL = 1'b1 // 1: timer 0 style, 0: timer 3 style
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // axi4-lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // capture inputs
   input wire logic capture_input_pin,
   input wire logic timer_clock_pin,
   input wire logic filter_input_pin
);

   localparam int FLAG_DLY = `FLAG_DELAY_CYC; // half clock, rounded up
   localparam logic [CNT_W-1:0] CNT_MAX = '1;

   // bus front end wires
   logic wr_en;
   logic [7:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;
   logic wr_err, rd_err;

   // software registers
   logic timer_on, next_timer_on;
   logic [`CTRL1_W-1:0] timer_control_1, next_timer_control_1;
   logic [CNT_W-1:0] period_reg, next_period_reg;
   logic [CNT_W-1:0] capture_reg_a, next_capture_reg_a;
   logic [CNT_W-1:0] capture_reg_b, next_capture_reg_b;
   logic compare_a_flag, next_compare_a_flag;
   logic compare_p_flag, next_compare_p_flag;
   logic capture_level_flag, next_capture_level_flag;

   // counter state
   logic [CNT_W-1:0] count, next_count;
   logic on_d, next_on_d; // on bit one clock ago
   logic [FLAG_DLY-1:0] cap_pend, next_cap_pend; // flag delay line
   logic [FLAG_DLY:0] pend_shift;
   logic lvl_hold, next_lvl_hold; // level seen at capture

   // decoded fields
   capture_timer_pkg::mode_t mode;
   capture_timer_pkg::edge_sel_t edge_sel;
   logic [1:0] counter_clear_sel;
   logic capture_source_select, nf_select;
   logic [2:0] unused_ctrl; // kept for readback only

   // event terms
   logic cap_src, cap_rise, cap_fall;
   logic trig_rise;
   logic cap_on, cap_ev, clr_ev, per_hit, on_rise, to_b, sp_mode;

   // bus slave
   axil_slave u_bus (
      .clk(clk),
      .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(wr_err),
      .rd_en(),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   // capture source select
   always_comb begin
      if (!DUAL) begin
         cap_src = timer_clock_pin;
      end else if (nf_select) begin
         cap_src = filter_input_pin;
      end else begin
         cap_src = capture_source_select ? timer_clock_pin : capture_input_pin;
      end
   end

   // glitch filter on capture source
   capture_edge_filter #(
      .SAMPLES(`MIN_PULSE_TCLK)
   ) u_cap_filt (
      .clk(clk),
      .resetn(resetn),
      .din(cap_src),
      .level(),
      .rise(cap_rise),
      .fall(cap_fall)
   );

   // glitch filter on single pulse trigger pin
   capture_edge_filter #(
      .SAMPLES(`MIN_PULSE_TCLK)
   ) u_trig_filt (
      .clk(clk),
      .resetn(resetn),
      .din(timer_clock_pin),
      .level(),
      .rise(trig_rise),
      .fall()
   );

   // field decode
   always_comb begin
      mode = capture_timer_pkg::mode_t'(timer_control_1[`CTRL1_MODE_LSB +: 2]);
      edge_sel = capture_timer_pkg::edge_sel_t'(timer_control_1[`CTRL1_OC_LSB +: 2]);
      counter_clear_sel = timer_control_1[`CTRL1_CLR_LSB +: 2];
      capture_source_select = timer_control_1[`CTRL1_SRC_BIT];
      nf_select = timer_control_1[`CTRL1_NF_BIT];
      // clear-on-A, initial level and polarity steer nothing here
      unused_ctrl = {timer_control_1[`CTRL1_POL_BIT], timer_control_1[`CTRL1_OINIT_BIT],
                     timer_control_1[`CTRL1_CCLR_BIT]};
   end

   // event decode
   always_comb begin
      cap_on = (mode == capture_timer_pkg::MODE_CAPTURE) && timer_on;
      on_rise = timer_on && !on_d;
      sp_mode = (mode == capture_timer_pkg::MODE_PWM) &&
                (edge_sel == capture_timer_pkg::EDGE_NONE);
      // none selected: no capture, counter keeps going
      unique case (edge_sel)
         capture_timer_pkg::EDGE_RISE: cap_ev = cap_on && cap_rise;
         capture_timer_pkg::EDGE_FALL: cap_ev = cap_on && cap_fall;
         capture_timer_pkg::EDGE_BOTH: cap_ev = cap_on && (cap_rise || cap_fall);
         capture_timer_pkg::EDGE_NONE: cap_ev = 1'b0;
      endcase
      // edge clears, only on the dual style timer
      clr_ev = DUAL && cap_on && ((cap_rise && counter_clear_sel[0]) ||
                                  (cap_fall && counter_clear_sel[1]));
      // falling edges go to b unless only period clears
      to_b = DUAL && (counter_clear_sel != 2'b00) && cap_fall;
      // period match, or full wrap when period is zero
      per_hit = timer_on && !on_rise &&
                ((period_reg != '0) ? (count == period_reg) : (count == CNT_MAX));
      pend_shift = {cap_pend, cap_ev};
   end

   // register reads
   always_comb begin
      rd_err = 1'b0;
      rd_data = `WORD_RST;
      unique case (rd_addr)
         `REG_CTRL0: rd_data[`CTRL0_ON_BIT] = timer_on;
         `REG_CTRL1: rd_data[`CTRL1_W-1:0] = timer_control_1;
         `REG_PERIOD: rd_data[CNT_W-1:0] = period_reg;
         `REG_CAPT_A: rd_data[CNT_W-1:0] = capture_reg_a;
         `REG_CAPT_B: rd_data[CNT_W-1:0] = capture_reg_b;
         `REG_COUNT: rd_data[CNT_W-1:0] = count;
         `REG_STATUS: begin
            rd_data[`STAT_AF_BIT] = compare_a_flag;
            rd_data[`STAT_PF_BIT] = compare_p_flag;
            rd_data[`STAT_LVL_BIT] = capture_level_flag;
         end
         default: rd_err = 1'b1; // unmapped
      endcase
   end

   // software writes, hardware sets, counter next values
   always_comb begin
      logic [31:0] w_ctrl0, w_ctrl1, w_per, w_stat;
      w_ctrl0 = capture_timer_pkg::apply_strb({31'h0, timer_on}, wr_data, wr_strb);
      w_ctrl1 = capture_timer_pkg::apply_strb({21'h0, timer_control_1}, wr_data, wr_strb);
      w_per = capture_timer_pkg::apply_strb({{(32-CNT_W){1'b0}}, period_reg}, wr_data,
                                            wr_strb);
      w_stat = capture_timer_pkg::apply_strb(`WORD_RST, wr_data, wr_strb);
      wr_err = !(wr_addr inside {`REG_CTRL0, `REG_CTRL1, `REG_PERIOD, `REG_CAPT_A,
                                 `REG_CAPT_B, `REG_COUNT, `REG_STATUS});
      next_timer_on = timer_on;
      next_timer_control_1 = timer_control_1;
      next_period_reg = period_reg;
      next_capture_reg_a = capture_reg_a;
      next_capture_reg_b = capture_reg_b;
      next_compare_a_flag = compare_a_flag;
      next_compare_p_flag = compare_p_flag;
      next_capture_level_flag = capture_level_flag;
      next_on_d = timer_on;
      next_cap_pend = pend_shift[FLAG_DLY-1:0];
      next_lvl_hold = lvl_hold;
      // register writes; status bits 0 and 1 clear on writing one, the level bit does not
      if (wr_en) begin
         unique case (wr_addr)
            `REG_CTRL0: next_timer_on = w_ctrl0[`CTRL0_ON_BIT];
            `REG_CTRL1: next_timer_control_1 = w_ctrl1[`CTRL1_W-1:0];
            `REG_PERIOD: next_period_reg = w_per[CNT_W-1:0];
            `REG_STATUS: begin
               if (w_stat[`STAT_AF_BIT]) begin
                  next_compare_a_flag = 1'b0;
               end
               if (w_stat[`STAT_PF_BIT]) begin
                  next_compare_p_flag = 1'b0;
               end
            end
            default: next_timer_on = timer_on; // read-only or unmapped
         endcase
      end
      // trigger pin sets the on bit, winning over software
      if (sp_mode && trig_rise) begin
         next_timer_on = 1'b1;
      end
      // latch counter at the active edge
      if (cap_ev) begin
         next_lvl_hold = cap_rise;
         if (to_b) begin
            next_capture_reg_b = count;
         end else begin
            next_capture_reg_a = count;
         end
      end
      // flags follow one clock after the latch; set wins over clear
      if (cap_pend[FLAG_DLY-1]) begin
         next_compare_a_flag = 1'b1;
         if (DUAL) begin
            next_capture_level_flag = lvl_hold;
         end
      end
      if (per_hit) begin
         next_compare_p_flag = 1'b1;
      end
      // counter: restart on on-rise, hold when off
      if (on_rise) begin
         next_count = '0;
      end else if (!timer_on) begin
         next_count = count;
      end else if (per_hit || clr_ev) begin
         next_count = '0;
      end else begin
         next_count = count + 1'b1;
      end
   end

   // state registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         timer_on <= 1'b0;
         timer_control_1 <= `CTRL1_RST;
         period_reg <= '0;
         capture_reg_a <= '0;
         capture_reg_b <= '0;
         compare_a_flag <= 1'b0;
         compare_p_flag <= 1'b0;
         capture_level_flag <= 1'b0;
         count <= '0;
         on_d <= 1'b0;
         cap_pend <= '0;
         lvl_hold <= 1'b0;
      end else begin
         timer_on <= next_timer_on;
         timer_control_1 <= next_timer_control_1;
         period_reg <= next_period_reg;
         capture_reg_a <= next_capture_reg_a;
         capture_reg_b <= next_capture_reg_b;
         compare_a_flag <= next_compare_a_flag;
         compare_p_flag <= next_compare_p_flag;
         capture_level_flag <= next_capture_level_flag;
         count <= next_count;
         on_d <= next_on_d;
         cap_pend <= next_cap_pend;
         lvl_hold <= next_lvl_hold;
      end
   end

endmodule

// ### periodic_timer_capture_mode_tb.sv
`timescale 1ns/100ps
`include "capture_timer_cfg.svh"
module periodic_timer_capture_mode_tb;
   // expected read: data, compare mask, response
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rd_exp_t;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic cap_pin, tclk_pin, flt_pin;
   rd_exp_t rq[$];
   logic [1:0] bq[$];
   int mismatches = 0;
   int cmp_count = 0;
   int h, p;

   // 40 mhz timer clock
   initial begin
      forever #12.5 clk = ~clk;
   end

   // short counter keeps the full-count wrap quick
   periodic_timer_capture #(.CNT_W(10), .DUAL(1'b1)) dut (
      .clk(clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .capture_input_pin(cap_pin), .timer_clock_pin(tclk_pin), .filter_input_pin(flt_pin)
   );

   // far-side pulse source
   capture_pulse_source src (.clk(clk), .cap_pin(cap_pin), .tclk_pin(tclk_pin), .flt_pin(flt_pin));

   // verdict and end of run
   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // data compare
   task automatic chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // response compare
   task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // a wait that ran out
   task automatic hung(input string nm);
      mismatches++;
      $display("mismatch %s expected answer seen none", nm);
      complete_run();
   endtask

   // bus write
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] r);
      int n;
      n = 0;
      bq.push_back(r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 50);
      s_axi_bready <= 1'b0;
      if (!s_axi_bvalid) hung("bresp");
   endtask

   // bus read
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [1:0] r);
      int n;
      n = 0;
      rq.push_back('{d, m, r});
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 50);
      s_axi_rready <= 1'b0;
      if (!s_axi_rvalid) hung("rdata");
   endtask

   // control word; bits 9..7 random since capture mode ignores them
   function automatic logic [31:0] c1(input logic [1:0] md, input logic [1:0] ed,
                                      input logic [1:0] cl, input int src);
      return {21'h0, src == 2, 3'($urandom), src == 1, cl, ed, md};
   endfunction

   // monitor: oldest note against each answer
   always @(posedge clk) begin
      rd_exp_t e;
      if (s_axi_bvalid && s_axi_bready) begin
         chk_resp("bresp", bq.pop_front(), s_axi_bresp);
      end
      if (s_axi_rvalid && s_axi_rready) begin
         e = rq.pop_front();
         chk_data("rdata", e.d & e.m, s_axi_rdata & e.m);
         chk_resp("rresp", e.r, s_axi_rresp);
      end
   end

   // main sequence
   initial begin
      void'($urandom(84910));
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      // reset values and refusals
      for (int a = 0; a <= `REG_STATUS; a += 4) rd(8'(a), 32'h0, 32'hffff_ffff, `RESP_OKAY);
      rd(8'h1c, 32'h0, 32'hffff_ffff, `RESP_SLVERR);
      wr(8'h1c, 32'h5, 4'hf, `RESP_SLVERR);
      wr(`REG_CTRL1, 32'h755, 4'b0010, `RESP_OKAY);
      rd(`REG_CTRL1, 32'h700, 32'h7ff, `RESP_OKAY);
      // every source and edge select, clear field 00
      wr(`REG_CTRL0, 32'h1, 4'hf, `RESP_OKAY);
      for (int s = 0; s < 3; s++) begin
         for (int e = 0; e < 4; e++) begin
            wr(`REG_CTRL1, c1(2'b01, 2'(e), 2'b00, s), 4'hf, `RESP_OKAY);
            wr(`REG_STATUS, 32'h7, 4'hf, `RESP_OKAY);
            src.pulse(s, 4);
            rd(`REG_STATUS, {31'h0, e != 3}, 32'h1, `RESP_OKAY);
         end
      end
      rd(`REG_CAPT_B, 32'h0, 32'hffff_ffff, `RESP_OKAY);
      // one-clock glitch is dropped
      wr(`REG_CTRL1, c1(2'b01, 2'b00, 2'b00, 0), 4'hf, `RESP_OKAY);
      wr(`REG_STATUS, 32'h7, 4'hf, `RESP_OKAY);
      src.pulse(0, 1);
      rd(`REG_STATUS, 32'h0, 32'h1, `RESP_OKAY);
      // pulse width with edge clears: falling capture into b
      for (int c = 1; c <= 3; c += 2) begin
         h = 5 + $urandom_range(25);
         wr(`REG_CTRL1, c1(2'b01, 2'b10, 2'(c), 0), 4'hf, `RESP_OKAY);
         wr(`REG_STATUS, 32'h7, 4'hf, `RESP_OKAY);
         src.pulse(0, h);
         rd(`REG_CAPT_B, 32'(h - 1), 32'hffff_ffff, `RESP_OKAY);
         rd(`REG_STATUS, 32'h1, 32'h5, `RESP_OKAY);
      end
      // period match, then stopped counter
      wr(`REG_CTRL0, 32'h0, 4'hf, `RESP_OKAY);
      p = 20 + $urandom_range(20);
      wr(`REG_PERIOD, 32'(p), 4'hf, `RESP_OKAY);
      wr(`REG_CTRL1, c1(2'b01, 2'b11, 2'b00, 0), 4'hf, `RESP_OKAY);
      wr(`REG_STATUS, 32'h7, 4'hf, `RESP_OKAY);
      wr(`REG_CTRL0, 32'h1, 4'hf, `RESP_OKAY);
      rd(`REG_STATUS, 32'h0, 32'h2, `RESP_OKAY);
      repeat (p + 4) @(posedge clk);
      rd(`REG_STATUS, 32'h2, 32'h2, `RESP_OKAY);
      wr(`REG_CTRL0, 32'h0, 4'hf, `RESP_OKAY);
      wr(`REG_STATUS, 32'h2, 4'hf, `RESP_OKAY);
      repeat (p + 4) @(posedge clk);
      rd(`REG_STATUS, 32'h0, 32'h2, `RESP_OKAY);
      // zero period runs to the full 10-bit count
      wr(`REG_PERIOD, 32'h0, 4'hf, `RESP_OKAY);
      wr(`REG_CTRL0, 32'h1, 4'hf, `RESP_OKAY);
      repeat (900) @(posedge clk);
      rd(`REG_STATUS, 32'h0, 32'h2, `RESP_OKAY);
      repeat (200) @(posedge clk);
      rd(`REG_STATUS, 32'h2, 32'h2, `RESP_OKAY);
      // single pulse: clock pin edge turns the timer on
      wr(`REG_CTRL0, 32'h0, 4'hf, `RESP_OKAY);
      wr(`REG_CTRL1, c1(2'b10, 2'b11, 2'b00, 0), 4'hf, `RESP_OKAY);
      src.pulse(1, 4);
      rd(`REG_CTRL0, 32'h1, 32'h1, `RESP_OKAY);
      repeat (4) @(posedge clk);
      complete_run();
   end
endmodule

// ### periodic_timer_capture_props.sv
`timescale 1ns/100ps
`include "capture_timer_cfg.svh"
// bus-level checks on the capture timer's register port
module periodic_timer_capture_props #(
   parameter int CNT_W = 16,
   parameter bit DUAL = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // write side
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read side
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // address and data taken at one edge
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // read address taken
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data late");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   a_rvalid_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
   a_unmapped_read: assert property (rd_taken ##0 s_axi_araddr > `REG_STATUS
      |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_mapped_read: assert property (rd_taken ##0 s_axi_araddr <= `REG_STATUS |=> s_axi_rresp == `RESP_OKAY)
      else $error("mapped read refused");
endmodule

bind periodic_timer_capture periodic_timer_capture_props #(.CNT_W(CNT_W), .DUAL(DUAL)) u_props (
   .clk(clk), .resetn(resetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
